// file: dv/vpic_chk.sv
// Assertion checker for the interrupt controller top level
`timescale 1ns/100ps
module vpic_chk
   import vpic_pkg::*;
(
   input wire logic               clock_i,
   input wire logic               rst_n_i,
   input wire logic [7:0]         reg_addr_i,
   input wire logic [7:0]         reg_wdata_i,
   input wire logic               reg_wr_i,
   input wire logic               reg_rd_i,
   input wire logic [7:0]         reg_rdata_o,
   input wire logic               hw_reset_source_i,
   input wire logic               core_ack_i,
   input wire logic               return_from_service_i,
   input wire logic               irq_req_o,
   input wire logic               irq_reset_src_o,
   input wire logic [15:0]        irq_vector_o,
   input wire logic [1:0]         irq_level_o,
   input wire logic               master_irq_enable_o
);
   default clocking @(posedge clock_i); endclocking
   default disable iff (!rst_n_i);
   rdata_idle_a: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 8'h00)
      else $error("read data outside answer cycle");
   ack_drops_a: assert property (core_ack_i && irq_req_o |=> !irq_req_o && !master_irq_enable_o)
      else $error("accept did not clear request and enable");
   ret_sets_a: assert property (return_from_service_i && !core_ack_i |=> master_irq_enable_o)
      else $error("return did not set enable");
   ea_rise_a: assert property ($rose(master_irq_enable_o) |-> $past(return_from_service_i) ||
      $past(reg_wr_i && reg_addr_i == ADDR_EN_A && reg_wdata_i[7]))
      else $error("enable rose without cause");
   ea_gate_a: assert property (!master_irq_enable_o |=> !irq_req_o || irq_reset_src_o)
      else $error("maskable request while disabled");
   rst_vec_a: assert property (irq_reset_src_o |-> irq_req_o && irq_vector_o == 16'h0000 &&
      irq_level_o == 2'h0)
      else $error("reset source vector wrong");
   mask_vec_a: assert property (irq_req_o && !irq_reset_src_o |-> irq_vector_o[2:0] == 3'h3 &&
      irq_vector_o <= 16'h00BB)
      else $error("maskable vector wrong");
   idle_vec_a: assert property (!irq_req_o |-> irq_vector_o == 16'h0000)
      else $error("vector without request");
   rst_lat_a: assert property ($rose(hw_reset_source_i) |-> ##[1:6] irq_reset_src_o)
      else $error("reset source late");
   cover property (core_ack_i && irq_reset_src_o);
   cover property (core_ack_i && irq_level_o == 2'h3);
   cover property (return_from_service_i);
endmodule : vpic_chk

bind vpic_top vpic_chk vpic_chk_inst (.clock_i(clock_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i),
   .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
   .hw_reset_source_i(hw_reset_source_i), .core_ack_i(core_ack_i),
   .return_from_service_i(return_from_service_i), .irq_req_o(irq_req_o),
   .irq_reset_src_o(irq_reset_src_o), .irq_vector_o(irq_vector_o), .irq_level_o(irq_level_o),
   .master_irq_enable_o(master_irq_enable_o));

// file: dv/vpic_core_model.sv
// Behavioural core that accepts, services and returns
`timescale 1ns/100ps
module vpic_core_model (
   input  wire logic        clock_i,
   input  wire logic        rst_n_i,
   input  wire logic        req_i,
   input  wire logic [15:0] vec_i,
   input  wire logic        hold_i,
   input  wire logic        slow_i,
   output logic             ack_o,
   output logic             ret_o,
   output logic      [15:0] vec_o,
   output logic      [7:0]  taken_o
);
   logic [2:0] wait_q;
   logic [3:0] depth;
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         {wait_q, depth, ack_o, ret_o, vec_o, taken_o} <= '0;
      end else begin
         ack_o <= 1'b0;
         ret_o <= 1'b0;
         if (req_i && !ack_o) begin
            wait_q <= wait_q + 3'h1;
            if (wait_q >= (slow_i ? 3'h5 : 3'h0)) begin
               ack_o   <= 1'b1;
               wait_q  <= 3'h0;
               vec_o   <= vec_i;
               taken_o <= taken_o + 8'h01;
               depth   <= depth + 4'h1;
            end
         end else if (!hold_i && depth != 4'h0 && !ret_o && !ack_o) begin
            ret_o <= 1'b1;
            depth <= depth - 4'h1;
         end
      end
   end
endmodule : vpic_core_model

// file: dv/vpic_top_test.sv
// Self-checking testbench of the interrupt controller
`timescale 1ns/100ps
module vpic_top_test;
   import vpic_pkg::*;
   logic clock_i = 0, rst_n_i = 0, wr = 0, rd = 0, rst_src = 0, hold = 0, slow = 0;
   logic [7:0]  addr = 8'h00, wdata = 8'h00, rdata, taken;
   logic [23:0] src = 24'h000000;
   logic        req, rsrc, ack, ret, ea;
   logic [15:0] vec, got_vec;
   logic [1:0]  lvl;
   int          err_total = 0, cmp_count = 0, cyc = 0;
   always #2 clock_i = ~clock_i;
   vpic_top vpic_top_inst (.clock_i(clock_i), .rst_n_i(rst_n_i), .reg_addr_i(addr), .reg_wdata_i(wdata),
      .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .irq_src_i(src), .hw_reset_source_i(rst_src),
      .core_ack_i(ack), .return_from_service_i(ret), .irq_req_o(req), .irq_reset_src_o(rsrc),
      .irq_vector_o(vec), .irq_level_o(lvl), .master_irq_enable_o(ea));
   vpic_core_model vpic_core_model_inst (.clock_i(clock_i), .rst_n_i(rst_n_i), .req_i(req), .vec_i(vec),
      .hold_i(hold), .slow_i(slow), .ack_o(ack), .ret_o(ret), .vec_o(got_vec), .taken_o(taken));
   task automatic final_report;
      $display("errors %0d compares %0d", err_total, cmp_count);
      if (err_total == 0 && cmp_count > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : final_report
   always @(posedge clock_i) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         err_total = err_total + 1;
         final_report();
      end
   end
   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      cmp_count++;
      if (g !== e) begin
         err_total++;
         $display("wrong value at %0t got %h exp %h", $time, g, e);
      end
   endtask : chk
   task automatic wrr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock_i) {wr, addr, wdata} <= {1'b1, a, d};
      @(posedge clock_i) wr <= 1'b0;
   endtask : wrr
   task automatic rdr(input logic [7:0] a, input logic [7:0] e);
      @(posedge clock_i) {rd, addr} <= {1'b1, a};
      @(posedge clock_i) rd <= 1'b0;
      #1 chk({8'h00, rdata}, {8'h00, e});
   endtask : rdr
   task automatic take(input logic [15:0] e);
      logic [7:0] t;
      t = taken;
      for (int i = 0; i < 200 && taken === t; i++) @(posedge clock_i);
      #1 chk(got_vec, e);
   endtask : take
   initial begin
      repeat (5) @(posedge clock_i);
      rst_n_i <= 1'b1;
      rdr(8'hA8, 8'h00); rdr(8'hA9, 8'h00); rdr(8'hAB, 8'h00);
      rdr(8'hB8, 8'h00); rdr(8'hF8, 8'h00);
      wrr(8'hB8, 8'hFF); rdr(8'hB8, 8'h3F); wrr(8'h00, 8'hFF); rdr(8'h00, 8'h00);
      wrr(8'hA8, 8'h08);
      @(posedge clock_i) src[3] <= 1'b1;
      repeat (8) @(posedge clock_i);
      src[3] <= 1'b0;
      #1 chk(req, 1'b0);
      rdr(8'h14, 8'h08);
      wrr(8'hA8, 8'h88); take(16'h001B);
      rdr(8'h14, 8'h00);
      wrr(8'h10, 8'hFF); wrr(8'h11, 8'hFF); wrr(8'h12, 8'hFF); wrr(8'hA9, 8'h3F);
      wrr(8'hAA, 8'h3F); wrr(8'hAB, 8'h3F); wrr(8'hB8, 8'h04); wrr(8'hF8, 8'h04); wrr(8'hA8, 8'hBF);
      @(posedge clock_i) src <= 24'h100103;
      take(16'h0043); take(16'h00A3); take(16'h0003); take(16'h000B);
      rdr(8'h14, 8'h00); rdr(8'h15, 8'h00); rdr(8'h16, 8'h00);
      @(posedge clock_i) {hold, slow, src} <= {2'b11, 24'h000000};
      repeat (4) @(posedge clock_i) src <= 24'h000001;
      take(16'h0003);
      chk(ea, 1'b0);
      wrr(8'hA8, 8'hBF);
      @(posedge clock_i) src[1] <= 1'b1;
      repeat (12) @(posedge clock_i);
      src[8] <= 1'b1;
      #1 chk(taken, 8'h06);
      take(16'h0043);
      @(posedge clock_i) hold <= 1'b0;
      take(16'h000B);
      wrr(8'hA8, 8'h00);
      @(posedge clock_i) rst_src <= 1'b1;
      take(16'h0000);
      @(posedge clock_i) rst_src <= 1'b0;
      repeat (10) @(posedge clock_i);
      final_report();
   end
endmodule : vpic_top_test

// file: rtl/vpic_arbiter.sv
// Level-then-index arbiter over the pending maskable requests
`timescale 1ns/100ps
module vpic_arbiter
   import vpic_pkg::*;
(
   input  wire logic [MAX_SRC-1:0] pend_i,
   input  wire logic [5:0]         pa_i,
   input  wire logic [5:0]         pb_i,
   output logic                    valid_o,
   output logic      [4:0]         idx_o,
   output logic      [1:0]         lvl_o
);
   logic [1:0] lvl_n;

   always_comb begin
      valid_o = 1'b0;
      idx_o   = 5'h00;
      lvl_o   = 2'h0;
      lvl_n   = 2'h0;
      // Walk downward so that on equal level the lower index wins
      for (int i = MAX_SRC - 1; i >= 0; i--) begin
         lvl_n = vpic_level(5'(i), pa_i, pb_i);
         if (pend_i[i] && (!valid_o || lvl_n >= lvl_o)) begin
            valid_o = 1'b1;
            idx_o   = 5'(i);
            lvl_o   = lvl_n;
         end
      end
   end
endmodule : vpic_arbiter

// file: rtl/vpic_pkg.sv
// Constants, types and helpers of the vectored priority interrupt controller
package vpic_pkg;
   localparam int          MAX_SRC       = 24;
   localparam int          GROUPS        = 6;
   localparam int          LEVELS        = 4;
   localparam int          EN_FIELD_W    = 6;
   localparam int          MASTER_EN_BIT = 7;
   localparam logic [7:0]  ADDR_EN_A     = 8'hA8;
   localparam logic [7:0]  ADDR_EN_B     = 8'hA9;
   localparam logic [7:0]  ADDR_EN_C     = 8'hAA;
   localparam logic [7:0]  ADDR_EN_D     = 8'hAB;
   localparam logic [7:0]  ADDR_PRIO_A   = 8'hB8;
   localparam logic [7:0]  ADDR_PRIO_B   = 8'hF8;
   localparam logic [7:0]  ADDR_TRIG_A   = 8'h10;
   localparam logic [7:0]  ADDR_TRIG_B   = 8'h11;
   localparam logic [7:0]  ADDR_TRIG_C   = 8'h12;
   localparam logic [7:0]  ADDR_PEND_A   = 8'h14;
   localparam logic [7:0]  ADDR_PEND_B   = 8'h15;
   localparam logic [7:0]  ADDR_PEND_C   = 8'h16;
   localparam logic [7:0]  ADDR_STATUS   = 8'h17;
   localparam logic [23:0] EN_RESET      = 24'h000000;
   localparam logic [5:0]  PRIO_RESET    = 6'h00;
   localparam logic [23:0] TRIG_RESET    = 24'h000000;
   localparam logic [15:0] VEC_RESET_SRC = 16'h0000;
   localparam logic [15:0] VEC_BASE      = 16'h0003;
   localparam int          CLKS_PER_MC   = 2;
   localparam int          LAT_MIN_MC    = 3;
   localparam int          LAT_MAX_MC    = 9;
   localparam int          LAT_MIN_CLKS  = LAT_MIN_MC * CLKS_PER_MC;
   localparam int          LAT_MAX_CLKS  = LAT_MAX_MC * CLKS_PER_MC;

   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } vpic_bus_t;

   typedef struct packed {
      logic        req;
      logic        rst_src;
      logic [1:0]  lvl;
      logic [4:0]  idx;
      logic [15:0] vec;
   } vpic_core_t;

   typedef struct packed {
      logic [7:0]  rdata;
      logic        ea;
      logic [23:0] en;
      logic [5:0]  pa;
      logic [5:0]  pb;
      logic [23:0] trig;
      logic [23:0] flag;
      logic [23:0] prev;
      logic        rst_flag;
      logic        rst_prev;
      logic [3:0]  insvc;
      logic        insvc_rst;
      vpic_core_t  core;
   } vpic_state_t;

   // Level of a source: group bit from both priority registers
   function automatic logic [1:0] vpic_level(input logic [4:0] n, input logic [5:0] pa, input logic [5:0] pb);
      logic [2:0] g;
      g = 3'(n % 5'h06);
      return {pb[g], pa[g]};
   endfunction : vpic_level

   // Vector of a maskable source: base plus eight per source
   function automatic logic [15:0] vpic_vector(input logic [4:0] n);
      return VEC_BASE + {8'h00, n, 3'h0};
   endfunction : vpic_vector
endpackage : vpic_pkg

// file: rtl/vpic_sync.sv
// Two-stage synchroniser for asynchronous request lines
`timescale 1ns/100ps
module vpic_sync #(
   parameter int WIDTH = 25
) (
   input  wire logic             clock_i,
   input  wire logic             rst_n_i,
   input  wire logic [WIDTH-1:0] async_i,
   output logic      [WIDTH-1:0] sync_o
);
   logic [WIDTH-1:0] stage1;

   if (WIDTH < 1) begin : g_bad_width
      $error("vpic_sync: WIDTH must be at least 1");
   end

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         stage1 <= '0;
         sync_o <= '0;
      end else begin
         stage1 <= async_i;
         sync_o <= stage1;
      end
   end
endmodule : vpic_sync

// file: rtl/vpic_top.sv
// Vectored priority interrupt controller top level
`timescale 1ns/100ps
module vpic_top
   import vpic_pkg::*;
#(
   parameter int NUM_SRC = 24
) (
   input  wire logic               clock_i,
   input  wire logic               rst_n_i,
   input  wire logic [7:0]         reg_addr_i,
   input  wire logic [7:0]         reg_wdata_i,
   input  wire logic               reg_wr_i,
   input  wire logic               reg_rd_i,
   output logic      [7:0]         reg_rdata_o,
   input  wire logic [MAX_SRC-1:0] irq_src_i,
   input  wire logic               hw_reset_source_i,
   input  wire logic               core_ack_i,
   input  wire logic               return_from_service_i,
   output logic                    irq_req_o,
   output logic                    irq_reset_src_o,
   output logic      [15:0]        irq_vector_o,
   output logic      [1:0]         irq_level_o,
   output logic                    master_irq_enable_o
);
   localparam logic [MAX_SRC-1:0] SRC_MASK = MAX_SRC'((25'h0000001 << NUM_SRC) - 25'h0000001);

   vpic_state_t      s;
   vpic_state_t      next_s;
   vpic_bus_t        bus;
   logic [MAX_SRC:0] sync_all;
   logic [23:0]      src;
   logic             rst_src;
   logic [23:0]      set_v;
   logic [23:0]      clr_v;
   logic [23:0]      pend;
   logic             win_valid;
   logic [4:0]       win_idx;
   logic [1:0]       win_lvl;
   logic             any_insvc;
   logic [1:0]       cur_lvl;
   logic             allow_mask;
   logic             do_ack;

   if (NUM_SRC < 1 || NUM_SRC > MAX_SRC) begin : g_bad_num
      $error("vpic_top: NUM_SRC out of range");
   end

   assign bus = '{wr: reg_wr_i, rd: reg_rd_i, addr: reg_addr_i, wdata: reg_wdata_i};

   vpic_sync #(
      .WIDTH (MAX_SRC + 1)
   ) u_sync (
      .clock_i (clock_i),
      .rst_n_i (rst_n_i),
      .async_i ({hw_reset_source_i, irq_src_i}),
      .sync_o  (sync_all)
   );

   assign src     = sync_all[MAX_SRC-1:0] & SRC_MASK;
   assign rst_src = sync_all[MAX_SRC];

   // Request only reaches the arbiter when master and own enable are set
   assign pend = s.flag & s.en & {MAX_SRC{s.ea}};

   vpic_arbiter u_arb (
      .pend_i  (pend),
      .pa_i    (s.pa),
      .pb_i    (s.pb),
      .valid_o (win_valid),
      .idx_o   (win_idx),
      .lvl_o   (win_lvl)
   );

   assign do_ack = core_ack_i && s.core.req;

   always_comb begin
      next_s     = s;
      next_s.rdata = 8'h00;
      set_v      = 24'h000000;
      clr_v      = 24'h000000;
      any_insvc  = |s.insvc;
      cur_lvl    = 2'h0;
      allow_mask = 1'b0;

      // Register writes
      if (bus.wr) begin
         case (bus.addr)
            ADDR_EN_A: begin
               next_s.ea      = bus.wdata[MASTER_EN_BIT];
               next_s.en[5:0] = bus.wdata[EN_FIELD_W-1:0];
            end
            ADDR_EN_B:   next_s.en[11:6]  = bus.wdata[EN_FIELD_W-1:0];
            ADDR_EN_C:   next_s.en[17:12] = bus.wdata[EN_FIELD_W-1:0];
            ADDR_EN_D:   next_s.en[23:18] = bus.wdata[EN_FIELD_W-1:0];
            ADDR_PRIO_A: next_s.pa        = bus.wdata[GROUPS-1:0];
            ADDR_PRIO_B: next_s.pb        = bus.wdata[GROUPS-1:0];
            ADDR_TRIG_A: next_s.trig[7:0]   = bus.wdata;
            ADDR_TRIG_B: next_s.trig[15:8]  = bus.wdata;
            ADDR_TRIG_C: next_s.trig[23:16] = bus.wdata;
            default: ;
         endcase
      end

      // Register reads, data stand in the following cycle only
      if (bus.rd) begin
         case (bus.addr)
            ADDR_EN_A:   next_s.rdata = {s.ea, 1'b0, s.en[5:0]};
            ADDR_EN_B:   next_s.rdata = {2'h0, s.en[11:6]};
            ADDR_EN_C:   next_s.rdata = {2'h0, s.en[17:12]};
            ADDR_EN_D:   next_s.rdata = {2'h0, s.en[23:18]};
            ADDR_PRIO_A: next_s.rdata = {2'h0, s.pa};
            ADDR_PRIO_B: next_s.rdata = {2'h0, s.pb};
            ADDR_TRIG_A: next_s.rdata = s.trig[7:0];
            ADDR_TRIG_B: next_s.rdata = s.trig[15:8];
            ADDR_TRIG_C: next_s.rdata = s.trig[23:16];
            ADDR_PEND_A: next_s.rdata = s.flag[7:0];
            ADDR_PEND_B: next_s.rdata = s.flag[15:8];
            ADDR_PEND_C: next_s.rdata = s.flag[23:16];
            ADDR_STATUS: next_s.rdata = {3'h0, s.insvc_rst, s.insvc};
            default:     next_s.rdata = 8'h00;
         endcase
      end

      // Edge mode catches a rising input, level mode the high input
      set_v       = (s.trig & src & ~s.prev) | (~s.trig & src);
      next_s.prev = src;
      next_s.rst_prev = rst_src;

      // Return from service: close the innermost active level
      if (return_from_service_i) begin
         next_s.ea = 1'b1;
         if (s.insvc_rst) begin
            next_s.insvc_rst = 1'b0;
         end else begin
            for (int l = 0; l < LEVELS; l++) begin
               if (s.insvc[l]) begin
                  cur_lvl = 2'(l);
               end
            end
            if (any_insvc) begin
               next_s.insvc[cur_lvl] = 1'b0;
            end
         end
      end

      // Acceptance by the core
      if (do_ack) begin
         next_s.ea = 1'b0;
         if (s.core.rst_src) begin
            next_s.insvc_rst = 1'b1;
         end else begin
            clr_v[s.core.idx]        = 1'b1;
            next_s.insvc[s.core.lvl] = 1'b1;
         end
      end

      // A new arrival wins over the clear of the same cycle
      next_s.flag     = (s.flag & ~clr_v) | set_v;
      next_s.rst_flag = (s.rst_flag & ~(do_ack & s.core.rst_src)) | (rst_src & ~s.rst_prev);

      // Level of the service now running
      cur_lvl = 2'h0;
      for (int l = 0; l < LEVELS; l++) begin
         if (s.insvc[l]) begin
            cur_lvl = 2'(l);
         end
      end
      allow_mask = win_valid && !s.insvc_rst && (!any_insvc || win_lvl > cur_lvl);

      // Presentation to the core, withdrawn in the cycle after acceptance
      next_s.core = '{req: 1'b0, rst_src: 1'b0, lvl: 2'h0, idx: 5'h00, vec: VEC_RESET_SRC};
      if (!do_ack) begin
         if (s.rst_flag && !s.insvc_rst) begin
            next_s.core.req     = 1'b1;
            next_s.core.rst_src = 1'b1;
            next_s.core.vec     = VEC_RESET_SRC;
         end else if (allow_mask) begin
            next_s.core.req = 1'b1;
            next_s.core.idx = win_idx;
            next_s.core.lvl = win_lvl;
            next_s.core.vec = vpic_vector(win_idx);
         end
      end
   end

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s.rdata     <= 8'h00;
         s.ea        <= 1'b0;
         s.en        <= EN_RESET;
         s.pa        <= PRIO_RESET;
         s.pb        <= PRIO_RESET;
         s.trig      <= TRIG_RESET;
         s.flag      <= 24'h000000;
         s.prev      <= 24'h000000;
         s.rst_flag  <= 1'b0;
         s.rst_prev  <= 1'b0;
         s.insvc     <= 4'h0;
         s.insvc_rst <= 1'b0;
         s.core      <= '{req: 1'b0, rst_src: 1'b0, lvl: 2'h0, idx: 5'h00, vec: VEC_RESET_SRC};
      end else begin
         s <= next_s;
      end
   end

   assign reg_rdata_o         = s.rdata;
   assign irq_req_o           = s.core.req;
   assign irq_reset_src_o     = s.core.rst_src;
   assign irq_vector_o        = s.core.vec;
   assign irq_level_o         = s.core.lvl;
   assign master_irq_enable_o = s.ea;
endmodule : vpic_top
